/* File: rtl/scan_bridge.sv */
// Contract
// - Test reset low forces bridge TAP and all local ports to parked reset.
// - A port parked in reset holds its local mode-select output at 1.
// - Update-IR selects the bridge whose slot pins match the shifted address.
// - Capture-IR loads 01 in the low bits and slot pins above.
// - Return-to-wait instruction sends every bridge to wait-for-address.
// - Config-select instruction puts the config register in the scan path.
// - Config value 00000111 chains all three local ports in series.
// - Unpark inserts the configured local ports into the scan chain.
// - After unpark, local TAPs are brought into step before scanning.
// - Address 3B selects every bridge regardless of slot pins.
// - Local reset instruction drives all local mode-selects high.
// - Park-in-reset forces the configured ports' local mode-selects high and parks those ports.
// - Park-in-idle parks chosen unparked ports in Run-Test/Idle; chosen ports already parked in reset stay in reset.
module scan_bridge #(
   parameter int NPORT = scan_bridge_pkg::NPORT
) (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic tck_b_i,
   input wire logic trst_n_i,
   input wire logic tms_b_i,
   input wire logic tdi_b_i,
   input wire logic [scan_bridge_pkg::SLOT_W-1:0] slot_id_pins_i,
   input wire logic [NPORT-1:0] tdi_l_i,
   output logic tdo_b_o,
   output logic tdo_b_oe_n_o,
   output logic [NPORT-1:0] tms_l_o,
   output logic [NPORT-1:0] tdo_l_o,
   output logic selected_o,
   output logic unparked_o
);
   localparam int IW = scan_bridge_pkg::IR_W;
   localparam int CW = scan_bridge_pkg::CFG_W;
   localparam int SW = scan_bridge_pkg::SLOT_W;

   function automatic scan_bridge_pkg::tap_state_t tap_next(
      input scan_bridge_pkg::tap_state_t s, input logic tms);
      case (s)
         scan_bridge_pkg::TLR: tap_next = tms ? scan_bridge_pkg::TLR : scan_bridge_pkg::RTI;
         scan_bridge_pkg::RTI: tap_next = tms ? scan_bridge_pkg::SEL_DR : scan_bridge_pkg::RTI;
         scan_bridge_pkg::SEL_DR: tap_next = tms ? scan_bridge_pkg::SEL_IR : scan_bridge_pkg::CAP_DR;
         scan_bridge_pkg::CAP_DR: tap_next = tms ? scan_bridge_pkg::EX1_DR : scan_bridge_pkg::SH_DR;
         scan_bridge_pkg::SH_DR: tap_next = tms ? scan_bridge_pkg::EX1_DR : scan_bridge_pkg::SH_DR;
         scan_bridge_pkg::EX1_DR: tap_next = tms ? scan_bridge_pkg::UPD_DR : scan_bridge_pkg::PA_DR;
         scan_bridge_pkg::PA_DR: tap_next = tms ? scan_bridge_pkg::EX2_DR : scan_bridge_pkg::PA_DR;
         scan_bridge_pkg::EX2_DR: tap_next = tms ? scan_bridge_pkg::UPD_DR : scan_bridge_pkg::SH_DR;
         scan_bridge_pkg::UPD_DR: tap_next = tms ? scan_bridge_pkg::SEL_DR : scan_bridge_pkg::RTI;
         scan_bridge_pkg::SEL_IR: tap_next = tms ? scan_bridge_pkg::TLR : scan_bridge_pkg::CAP_IR;
         scan_bridge_pkg::CAP_IR: tap_next = tms ? scan_bridge_pkg::EX1_IR : scan_bridge_pkg::SH_IR;
         scan_bridge_pkg::SH_IR: tap_next = tms ? scan_bridge_pkg::EX1_IR : scan_bridge_pkg::SH_IR;
         scan_bridge_pkg::EX1_IR: tap_next = tms ? scan_bridge_pkg::UPD_IR : scan_bridge_pkg::PA_IR;
         scan_bridge_pkg::PA_IR: tap_next = tms ? scan_bridge_pkg::EX2_IR : scan_bridge_pkg::PA_IR;
         scan_bridge_pkg::EX2_IR: tap_next = tms ? scan_bridge_pkg::UPD_IR : scan_bridge_pkg::SH_IR;
         scan_bridge_pkg::UPD_IR: tap_next = tms ? scan_bridge_pkg::SEL_DR : scan_bridge_pkg::RTI;
         default: tap_next = scan_bridge_pkg::TLR;
      endcase
   endfunction

   scan_bridge_pkg::tap_state_t state_ff, nxt_state;
   logic [SW-1:0] slot_m_ff, slot_ff;
   logic [IW-1:0] ir_sh_ff, nxt_ir_sh, instr_ff, nxt_instr;
   logic [CW-1:0] dr_sh_ff, nxt_dr_sh, cfg_ff, nxt_cfg;
   logic sel_ff, nxt_sel, wait_ff, nxt_wait;
   logic [NPORT-1:0] parked_ff, nxt_parked, idle_ff, nxt_idle, pend_ff, nxt_pend;
   logic [NPORT-1:0] tms_l_ff, nxt_tms_l, tdo_l_ff, nxt_tdo_l;
   logic tdo_b_ff, nxt_tdo_b, oe_n_ff, nxt_oe_n;
   logic uir;
   logic [2:0] sel_sy_ff, unp_sy_ff;

   assign uir = (state_ff == scan_bridge_pkg::UPD_IR);

   // Slot straps come from pins
   always_ff @(posedge tck_b_i or negedge trst_n_i)
   begin
      if (!trst_n_i)
      begin
         slot_m_ff <= '0;
         slot_ff <= '0;
      end
      else
      begin
         slot_m_ff <= slot_id_pins_i;
         slot_ff <= slot_m_ff;
      end
   end

   always_comb
   begin
      nxt_state = tap_next(state_ff, tms_b_i);
      nxt_ir_sh = ir_sh_ff;
      nxt_instr = instr_ff;
      nxt_dr_sh = dr_sh_ff;
      nxt_cfg = cfg_ff;
      nxt_sel = sel_ff;
      nxt_wait = wait_ff;
      nxt_parked = parked_ff;
      nxt_idle = idle_ff;
      nxt_pend = pend_ff;
      case (state_ff)
         scan_bridge_pkg::CAP_IR: nxt_ir_sh = {slot_ff, scan_bridge_pkg::IR_CAPTURE_LSB};
         scan_bridge_pkg::SH_IR: nxt_ir_sh = {tdi_b_i, ir_sh_ff[IW-1:1]};
         scan_bridge_pkg::CAP_DR:
            nxt_dr_sh = (instr_ff == scan_bridge_pkg::PORT_CONFIG_SELECT_INSTR) ? cfg_ff : '0;
         scan_bridge_pkg::SH_DR:
            if (instr_ff == scan_bridge_pkg::PORT_CONFIG_SELECT_INSTR)
               nxt_dr_sh = {tdi_b_i, dr_sh_ff[CW-1:1]};
            else
               nxt_dr_sh = {{(CW-1){1'b0}}, tdi_b_i};
         scan_bridge_pkg::UPD_DR:
            if (sel_ff && instr_ff == scan_bridge_pkg::PORT_CONFIG_SELECT_INSTR)
               nxt_cfg = dr_sh_ff;
         scan_bridge_pkg::UPD_IR:
            if (ir_sh_ff == scan_bridge_pkg::RETURN_TO_WAIT_INSTR)
            begin
               nxt_wait = 1'b1;
               nxt_sel = 1'b0;
               nxt_instr = scan_bridge_pkg::BYPASS_INSTR;
            end
            else if (wait_ff)
            begin
               nxt_wait = 1'b0;
               nxt_sel = (ir_sh_ff[IW-1:SW] == '0) && (ir_sh_ff[SW-1:0] == slot_ff
                  || ir_sh_ff[SW-1:0] == scan_bridge_pkg::BROADCAST_ADDR);
            end
            else if (sel_ff)
            begin
               nxt_instr = ir_sh_ff;
               case (ir_sh_ff)
                  scan_bridge_pkg::UNPARK_INSTR:
                  begin
                     nxt_parked = parked_ff & ~cfg_ff[NPORT-1:0];
                     nxt_pend = pend_ff | (parked_ff & cfg_ff[NPORT-1:0]);
                  end
                  scan_bridge_pkg::LOCAL_RESET_INSTR:
                  begin
                     nxt_parked = '1;
                     nxt_idle = '0;
                     nxt_pend = '0;
                  end
                  scan_bridge_pkg::PARK_IN_RESET_INSTR:
                  begin
                     nxt_parked = parked_ff | cfg_ff[NPORT-1:0];
                     nxt_idle = idle_ff & ~cfg_ff[NPORT-1:0];
                     nxt_pend = pend_ff & ~cfg_ff[NPORT-1:0];
                  end
                  scan_bridge_pkg::PARK_IN_IDLE_INSTR:
                  begin
                     nxt_parked = parked_ff | cfg_ff[NPORT-1:0];
                     nxt_idle = idle_ff | (cfg_ff[NPORT-1:0] & ~parked_ff);
                     nxt_pend = pend_ff & ~cfg_ff[NPORT-1:0];
                  end
                  default: nxt_pend = pend_ff;
               endcase
            end
         // hold in idle until bridge reaches idle
         scan_bridge_pkg::RTI: nxt_pend = '0;
         default: nxt_pend = pend_ff;
      endcase
   end

   // test reset parks everything in reset
   always_ff @(posedge tck_b_i or negedge trst_n_i)
   begin
      if (!trst_n_i)
      begin
         state_ff <= scan_bridge_pkg::TLR;
         ir_sh_ff <= '0;
         instr_ff <= scan_bridge_pkg::BYPASS_INSTR;
         dr_sh_ff <= '0;
         cfg_ff <= scan_bridge_pkg::CFG_RESET;
         sel_ff <= 1'b0;
         wait_ff <= 1'b1;
         parked_ff <= '1;
         idle_ff <= '0;
         pend_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         ir_sh_ff <= nxt_ir_sh;
         instr_ff <= nxt_instr;
         dr_sh_ff <= nxt_dr_sh;
         cfg_ff <= nxt_cfg;
         sel_ff <= nxt_sel;
         wait_ff <= nxt_wait;
         parked_ff <= nxt_parked;
         idle_ff <= nxt_idle;
         pend_ff <= nxt_pend;
      end
   end

   // Falling-edge drive of local and backplane outputs; chain runs port 0 upward
   always_comb
   begin
      logic src;
      src = (state_ff == scan_bridge_pkg::SH_IR) ? ir_sh_ff[0] : dr_sh_ff[0];
      nxt_tdo_l = tdo_l_ff;
      for (int k = 0; k < NPORT; k++)
      begin
         // parked ports hold mode-select, ignore backplane
         if (parked_ff[k])
            nxt_tms_l[k] = ~idle_ff[k];
         else if (pend_ff[k])
            nxt_tms_l[k] = 1'b0;
         else
            nxt_tms_l[k] = tms_b_i;
         if (!parked_ff[k] && !pend_ff[k])
         begin
            nxt_tdo_l[k] = src;
            src = tdi_l_i[k];
         end
      end
      nxt_tdo_b = src;
      // drive only when selected and shifting
      nxt_oe_n = !(sel_ff && (state_ff == scan_bridge_pkg::SH_IR
         || state_ff == scan_bridge_pkg::SH_DR));
   end

   always_ff @(negedge tck_b_i or negedge trst_n_i)
   begin
      if (!trst_n_i)
      begin
         tms_l_ff <= '1;
         tdo_l_ff <= '0;
         tdo_b_ff <= 1'b1;
         oe_n_ff <= 1'b1;
      end
      else
      begin
         tms_l_ff <= nxt_tms_l;
         tdo_l_ff <= nxt_tdo_l;
         tdo_b_ff <= nxt_tdo_b;
         oe_n_ff <= nxt_oe_n;
      end
   end

   assign tms_l_o = tms_l_ff;
   assign tdo_l_o = tdo_l_ff;
   assign tdo_b_o = tdo_b_ff;
   assign tdo_b_oe_n_o = oe_n_ff;

   // Status levels cross into the system clock
   always_ff @(posedge mclk_i)
   begin
      if (!reset_n_i)
      begin
         sel_sy_ff <= '0;
         unp_sy_ff <= '0;
      end
      else
      begin
         sel_sy_ff <= {sel_sy_ff[1:0], sel_ff};
         unp_sy_ff <= {unp_sy_ff[1:0], ~&parked_ff};
      end
   end

   assign selected_o = sel_sy_ff[2];
   assign unparked_o = unp_sy_ff[2];

   default clocking cb @(posedge tck_b_i);
   endclocking
   default disable iff (!trst_n_i);

   chk_parked_tms_high: assert property (
      &(~(parked_ff & ~idle_ff) | tms_l_ff)) else $error("parked port tms not high");
   chk_capture_ir_pattern: assert property (
      state_ff == scan_bridge_pkg::CAP_IR
      |=> ir_sh_ff == {$past(slot_ff), scan_bridge_pkg::IR_CAPTURE_LSB})
      else $error("capture-ir pattern wrong");
   chk_addr_match_sel: assert property (
      uir && wait_ff && ir_sh_ff == {2'h0, slot_ff} |=> sel_ff && !wait_ff)
      else $error("matching address did not select");
   chk_broadcast_sel: assert property (
      uir && wait_ff && ir_sh_ff == {2'h0, scan_bridge_pkg::BROADCAST_ADDR} |=> sel_ff)
      else $error("broadcast did not select");
   chk_wait_return: assert property (
      uir && ir_sh_ff == scan_bridge_pkg::RETURN_TO_WAIT_INSTR |=> wait_ff && !sel_ff)
      else $error("return to wait missed");
   chk_cfg_update: assert property (
      state_ff == scan_bridge_pkg::UPD_DR && sel_ff
      && instr_ff == scan_bridge_pkg::PORT_CONFIG_SELECT_INSTR |=> cfg_ff == $past(dr_sh_ff))
      else $error("config register not updated");
   chk_unpark_ports: assert property (
      uir && sel_ff && !wait_ff && ir_sh_ff == scan_bridge_pkg::UNPARK_INSTR
      |=> parked_ff == ($past(parked_ff) & ~$past(cfg_ff[NPORT-1:0])))
      else $error("unpark wrong ports");
   chk_local_reset_tms: assert property (
      uir && sel_ff && !wait_ff && ir_sh_ff == scan_bridge_pkg::LOCAL_RESET_INSTR
      |=> ##1 (&tms_l_ff) [*5]) else $error("local reset tms not high");
   chk_sync_hold_low: assert property (
      |pend_ff |-> (tms_l_ff & pend_ff) == '0)
      else $error("pending port tms not low");
   chk_tdo_quiet: assert property (
      !sel_ff && $past(!sel_ff) |-> oe_n_ff) else $error("unselected bridge drives tdo");
   cov_select: cover property (uir && wait_ff ##1 sel_ff);
   cov_unpark: cover property (|pend_ff ##[1:20] state_ff == scan_bridge_pkg::RTI);
   cov_park_idle: cover property (|(parked_ff & idle_ff));
endmodule

/* File: rtl/scan_bridge_pkg.sv */
package scan_bridge_pkg;
   localparam int IR_W = 8;
   localparam int CFG_W = 8;
   localparam int SLOT_W = 6;
   localparam int NPORT = 3;
   // Capture pattern in the low instruction bits
   localparam logic [1:0] IR_CAPTURE_LSB = 2'h1;
   localparam logic [SLOT_W-1:0] BROADCAST_ADDR = 6'h3B;
   localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
   // Instruction codes sit above the address range
   localparam logic [IR_W-1:0] BYPASS_INSTR = 8'hFF;
   localparam logic [IR_W-1:0] RETURN_TO_WAIT_INSTR = 8'h81;
   localparam logic [IR_W-1:0] PORT_CONFIG_SELECT_INSTR = 8'h82;
   localparam logic [IR_W-1:0] UNPARK_INSTR = 8'h83;
   localparam logic [IR_W-1:0] LOCAL_RESET_INSTR = 8'h84;
   localparam logic [IR_W-1:0] PARK_IN_RESET_INSTR = 8'h85;
   localparam logic [IR_W-1:0] PARK_IN_IDLE_INSTR = 8'h86;
   typedef enum {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } tap_state_t;
endpackage

/* File: test/bscan_master.sv */
module bscan_master (
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   output logic trst_n_o,
   input wire logic tdo_i,
   input wire logic tdo_oe_n_i
);
   timeunit 1ns;
   timeprecision 100ps;
   logic line;
   assign line = tdo_oe_n_i ? 1'b1 : tdo_i;
   initial
   begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b1;
      trst_n_o = 1'b0;
   end
   // Test clock stands high between frames; inputs change mid-high so the
   // mode-select forwarded on the fall is the one the next rise takes
   task automatic step(input logic m, input logic d, output logic q);
      tms_o = m;
      tdi_o = d;
      #4 tck_o = 1'b0;
      #7.5 tck_o = 1'b1;
      q = line;
      #3.5;
   endtask
   task automatic walk(input logic [7:0] bits, input int n);
      logic q;
      for (int i = 0; i < n; i++)
      begin
         step(bits[i], 1'b0, q);
      end
   endtask
   task automatic reset_link;
      logic q;
      trst_n_o = 1'b0;
      #10 tck_o = 1'b1;
      #10 trst_n_o = 1'b1;
      #10 step(1'b0, 1'b0, q);
   endtask
   // From idle through one scan, eight bits LSB first, back to idle
   task automatic scan(input logic ir, input logic [7:0] din, output logic [7:0] dout);
      logic q;
      step(1'b1, 1'b0, q);
      if (ir)
         step(1'b1, 1'b0, q);
      walk(8'h00, 2);
      for (int i = 0; i < 8; i++)
      begin
         step(logic'(i == 7), din[i], q);
         dout[i] = q;
      end
      walk(8'h01, 2);
   endtask
   // poll one slot address then return to wait
   task automatic poll(input logic [7:0] addr, output logic [7:0] cap);
      scan(1'b1, addr, cap);
      scan(1'b1, scan_bridge_pkg::RETURN_TO_WAIT_INSTR, cap);
   endtask
endmodule

/* File: test/scan_bridge_tb.sv */
module scan_bridge_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk, reset_n, tck, trst_n, tms, tdi, tdo, oe_n, sel, unp;
   logic [5:0] slot;
   logic [2:0] tdi_l, tms_l, tdo_l;
   logic [7:0] cap;
   int n_mismatch;
   int check_count;
   scan_bridge i_dut (.mclk_i(mclk), .reset_n_i(reset_n), .tck_b_i(tck), .trst_n_i(trst_n),
      .tms_b_i(tms), .tdi_b_i(tdi), .slot_id_pins_i(slot), .tdi_l_i(tdi_l), .tdo_b_o(tdo),
      .tdo_b_oe_n_o(oe_n), .tms_l_o(tms_l), .tdo_l_o(tdo_l), .selected_o(sel),
      .unparked_o(unp));
   // Each local chain acts as a one-bit stage looped back to the bridge
   assign tdi_l = tdo_l;
   bscan_master i_master (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
      .tdo_i(tdo), .tdo_oe_n_i(oe_n));
   always #4 mclk = ~mclk;
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic settle;
      repeat (10) @(posedge mclk);
   endtask
   task automatic test_reset;
      i_master.reset_link();
      settle();
      check("local mode select", 8'(tms_l), 8'h07);
      check("data enable", 8'(oe_n), 8'h01);
      check("selected", 8'(sel), 8'h00);
      $display("test reset done");
   endtask
   task automatic test_poll;
      i_master.poll(8'h09, cap);
      check("empty slot capture", cap, 8'hFF);
      i_master.scan(1'b1, 8'h05, cap);
      settle();
      check("selected", 8'(sel), 8'h01);
      i_master.scan(1'b1, scan_bridge_pkg::RETURN_TO_WAIT_INSTR, cap);
      check("slot capture", cap, 8'h15);
      settle();
      check("selected", 8'(sel), 8'h00);
      i_master.poll({2'h0, scan_bridge_pkg::BROADCAST_ADDR}, cap);
      check("broadcast capture", cap, 8'h15);
      $display("test poll done");
   endtask
   task automatic test_ports;
      logic q;
      i_master.scan(1'b1, 8'h05, cap);
      i_master.scan(1'b1, scan_bridge_pkg::PORT_CONFIG_SELECT_INSTR, cap);
      i_master.scan(1'b0, 8'h07, cap);
      i_master.scan(1'b0, 8'h07, cap);
      check("config readback", cap, 8'h07);
      check("parked mode select", 8'(tms_l), 8'h07);
      i_master.scan(1'b1, scan_bridge_pkg::UNPARK_INSTR, cap);
      i_master.walk(8'h00, 2);
      settle();
      check("unparked", 8'(unp), 8'h01);
      i_master.step(1'b1, 1'b0, q);
      check("following high", 8'(tms_l), 8'h07);
      i_master.step(1'b0, 1'b0, q);
      check("following low", 8'(tms_l), 8'h00);
      i_master.walk(8'h03, 3);
      i_master.scan(1'b1, scan_bridge_pkg::PARK_IN_RESET_INSTR, cap);
      check("chained capture", cap, 8'hA8);
      i_master.walk(8'h00, 2);
      settle();
      check("parked in reset", {4'h0, unp, tms_l}, 8'h07);
      i_master.scan(1'b1, scan_bridge_pkg::UNPARK_INSTR, cap);
      i_master.walk(8'h00, 2);
      i_master.scan(1'b1, scan_bridge_pkg::PARK_IN_IDLE_INSTR, cap);
      i_master.step(1'b1, 1'b0, q);
      check("parked in idle", 8'(tms_l), 8'h00);
      i_master.walk(8'h06, 4);
      i_master.scan(1'b1, scan_bridge_pkg::LOCAL_RESET_INSTR, cap);
      i_master.walk(8'h00, 5);
      check("local reset", 8'(tms_l), 8'h07);
      i_master.scan(1'b1, scan_bridge_pkg::RETURN_TO_WAIT_INSTR, cap);
      $display("test ports done");
   endtask
   initial
   begin
      #100000;
      n_mismatch++;
      tally_and_finish();
   end
   initial
   begin
      mclk = 1'b0;
      reset_n = 1'b0;
      slot = 6'h00;
      n_mismatch = 0;
      check_count = 0;
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      slot <= 6'h05;
      settle();
      test_reset();
      test_poll();
      test_ports();
      tally_and_finish();
   end
endmodule
